// file: verilog/mcast_pkg.sv
// shared constants, types and helpers for the multicast group lookup
//------------------------------------------------------------------------------
// Overview of operation
// [R1] each ingress port looks up destination ID plus TT against its table
// [R2] eight multicast entries, copied in ingress lookup and replication engine
// [R3] an entry matches a 16-bit ID with TT=0 or 8-bit ID with TT=1
// [R4] a group hit forwards the packet to the replication engine
// [R5] copies go to every mask port except the arrival port
// [R6] a miss falls through to unicast lookup
// [R7] mask writes beyond the supported mask count are silently ignored
// [R8] add or remove of a port number above 15 is silently dropped
// [R9] disabled or powered-down ports are added and removed like any port
// [R10] software writes ID and mask number before the association write
// [R11] association command 11 with width selector binds the ID to the mask
// [R12] one ID per mask; the latest association sets ID and TT
// [R13] ports may be removed from a mask while it is bound
// [R14] copies still go to faulty or powered-down mask members
// [R15] a group is deleted by breaking its ID to mask binding
// [R16] write-to-verify reports whether an ID and TT pair is bound
// [R17] empty mask, or only the arrival port, means silent discard
// [R18] configuration word holds ID in upper half, mask number in low bits
// [R19] association words E0 for 16-bit IDs, 60 for 8-bit IDs
// [R20] per mask, the set-up write precedes its association write
// [R21] multicast IDs share the unicast destination ID and TT space
// [R22] command 10 removes the binding, ignoring present and port fields
// [R23] mask word 40 empties a mask; 0610 adds port 6 to mask 0
// [R24] every write updates ingress and engine table copies together
//------------------------------------------------------------------------------
package mcast_pkg;
	localparam int NUM_PORTS = 16;
	localparam int GROUP_ENTRIES = 8;
	localparam int GROUP_W = 3;
	localparam int PORT_W = 4;
	localparam int ID_W = 16;
	localparam int MAX_MASKS_DEF = 8;
	// register offsets, low address nibble
	localparam logic [3:0] OFS_MASK_CFG = 4'h0;
	localparam logic [3:0] OFS_DESTID_CFG = 4'h4;
	localparam logic [3:0] OFS_ASSOC = 4'h8;
	localparam logic [3:0] OFS_INFO = 4'hC;
	// mask configuration word fields
	localparam int MCFG_MASK_LSB = 16;
	localparam int MCFG_PORT_LSB = 8;
	localparam int MCFG_CMD_LSB = 4;
	localparam int PRESENT_BIT = 0;
	localparam logic [2:0] MCMD_VERIFY = 3'h0;
	localparam logic [2:0] MCMD_ADD = 3'h1;
	localparam logic [2:0] MCMD_DEL = 3'h2;
	localparam logic [2:0] MCMD_DEL_ALL = 3'h4;
	localparam logic [2:0] MCMD_ADD_ALL = 3'h5;
	localparam logic [7:0] LAST_PORT = 8'h0F;
	// destination ID configuration word fields
	localparam int DCFG_ID_LSB = 16;
	// association word fields
	localparam int ASSOC_LARGE_BIT = 7;
	localparam int ASSOC_CMD_LSB = 5;
	localparam logic [1:0] ACMD_VERIFY = 2'h0;
	localparam logic [1:0] ACMD_REMOVE = 2'h2;
	localparam logic [1:0] ACMD_BIND = 2'h3;
	// TT codes stored in an entry
	localparam logic TT_16 = 1'b0;
	localparam logic TT_8 = 1'b1;
	// bus answers and reset values
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] WORD_RESET = 32'h00000000;

	typedef struct packed {
		logic valid;
		logic tt;
		logic [ID_W-1:0] id;
	} entry_t;

	typedef struct packed {
		logic [ID_W-1:0] destId;
		logic tt;
		logic [PORT_W-1:0] ingress;
	} pkt_t;

	typedef struct packed {
		logic multicast;
		logic drop;
		logic [GROUP_W-1:0] group;
		logic [PORT_W-1:0] ingress;
		logic [NUM_PORTS-1:0] vector;
	} fwd_t;

	// one entry against one ID/TT pair; 8-bit IDs compare low byte only
	function automatic logic entryHit(entry_t e, logic [ID_W-1:0] id,
		logic tt);
		logic idEq;
		idEq = (tt == TT_8) ? (e.id[7:0] == id[7:0]) : (e.id == id);
		return e.valid && (e.tt == tt) && idEq;
	endfunction
endpackage

// file: verilog/group_match.sv
// priority matcher over one copy of the multicast group table
`timescale 1ns/1ps
module group_match #(
	parameter int ENTRIES = mcast_pkg::GROUP_ENTRIES
) (
	input wire mcast_pkg::entry_t [ENTRIES-1:0] groups,
	input wire logic [mcast_pkg::ID_W-1:0] destId,
	input wire logic tt,
	output logic hit,
	output logic [mcast_pkg::GROUP_W-1:0] index
);
	logic [ENTRIES-1:0] entryHits;

	//--------------------------------------------------------------------
	// per-entry compare
	//--------------------------------------------------------------------
	// same ID/TT space as unicast, so a miss is simply unicast
	for (genvar g = 0; g < ENTRIES; g++)
	begin : gen_cmp
		assign entryHits[g] = mcast_pkg::entryHit(groups[g], destId, tt); // [R1] [R3] [R21]
	end

	//--------------------------------------------------------------------
	// lowest entry wins
	//--------------------------------------------------------------------
	// bindings are kept unique and TT must match, so no two entries hit one lookup
	always_comb
	begin
		hit = |entryHits;
		index = '0;
		for (int i = ENTRIES - 1; i >= 0; i--)
		begin
			if (entryHits[i])
				index = mcast_pkg::GROUP_W'(i);
		end
	end
endmodule // group_match

// file: verilog/multicast_group_lookup.sv
// multicast group lookup with AXI4-Lite configuration registers
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module multicast_group_lookup #(
	parameter int MAX_MASKS = mcast_pkg::MAX_MASKS_DEF,
	parameter int ADDR_W = 12
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic pktValid,
	input wire mcast_pkg::pkt_t pkt,
	output logic fwdValid,
	output mcast_pkg::fwd_t fwd
);
	localparam int ENT = mcast_pkg::GROUP_ENTRIES;
	localparam int NP = mcast_pkg::NUM_PORTS;
	localparam logic [15:0] MASK_LIMIT = 16'(MAX_MASKS);

	// bus slave state
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [ADDR_W-1:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	// configuration state
	logic [31:0] maskCfg_reg, destIdCfg_reg, assocCfg_reg;
	logic presentFlag_reg, bindingValidFlag_reg;
	mcast_pkg::entry_t [ENT-1:0] ingTable_reg, engTable_reg, table_next;
	logic [ENT-1:0][NP-1:0] engMask_reg;
	// lookup pipeline
	logic s1Valid_reg, s1Hit_reg;
	mcast_pkg::pkt_t s1Pkt_reg;
	logic fwdValid_reg;
	mcast_pkg::fwd_t fwd_reg;

	//--------------------------------------------------------------------
	// write decode
	//--------------------------------------------------------------------
	logic wrFire, wrFull, wrMapped, wrMask, wrDest, wrAssoc;
	logic [15:0] cfgMaskNum, destMaskNum;
	logic [7:0] cfgPort;
	logic [2:0] cfgCmd;
	logic [1:0] assocCmd;
	logic assocLarge, cfgMaskOk, destMaskOk;
	logic [mcast_pkg::GROUP_W-1:0] cfgIdx, destIdx;
	logic [15:0] destId;
	logic destTt;

	// a write fires once address and data are both held
	assign wrFire = !awready_reg && !wready_reg && !bvalid_reg;
	// command registers act only on whole-word writes
	assign wrFull = (wStrb_reg == 4'hF);
	assign wrMapped = (awAddr_reg[ADDR_W-1:4] == '0) &&
		(awAddr_reg[1:0] == 2'h0);
	assign wrMask = wrFire && wrFull && wrMapped &&
		(awAddr_reg[3:0] == mcast_pkg::OFS_MASK_CFG);
	assign wrDest = wrFire && wrFull && wrMapped &&
		(awAddr_reg[3:0] == mcast_pkg::OFS_DESTID_CFG);
	assign wrAssoc = wrFire && wrFull && wrMapped &&
		(awAddr_reg[3:0] == mcast_pkg::OFS_ASSOC);

	// mask word: mask number up top, port and command below
	assign cfgMaskNum = wData_reg[mcast_pkg::MCFG_MASK_LSB +: 16];
	assign cfgPort = wData_reg[mcast_pkg::MCFG_PORT_LSB +: 8];
	assign cfgCmd = wData_reg[mcast_pkg::MCFG_CMD_LSB +: 3];
	assign cfgMaskOk = (cfgMaskNum < MASK_LIMIT); // [R7]
	assign cfgIdx = cfgMaskNum[mcast_pkg::GROUP_W-1:0];

	// set-up word: ID in upper half, mask number in low bits
	assign destId = destIdCfg_reg[mcast_pkg::DCFG_ID_LSB +: 16]; // [R18]
	assign destMaskNum = destIdCfg_reg[15:0];
	assign destMaskOk = (destMaskNum < MASK_LIMIT);
	assign destIdx = destMaskNum[mcast_pkg::GROUP_W-1:0];
	assign assocCmd = wData_reg[mcast_pkg::ASSOC_CMD_LSB +: 2];
	assign assocLarge = wData_reg[mcast_pkg::ASSOC_LARGE_BIT];
	assign destTt = assocLarge ? mcast_pkg::TT_16 : mcast_pkg::TT_8; // [R3]

	//--------------------------------------------------------------------
	// AXI4-Lite write channels
	//--------------------------------------------------------------------
	// address and data taken in either order, one write in flight
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= mcast_pkg::RESP_OKAY;
			awAddr_reg <= '0;
			wData_reg <= mcast_pkg::WORD_RESET;
			wStrb_reg <= 4'h0;
		end
		else
		begin
			if (awvalid && awready_reg)
			begin
				awAddr_reg <= awaddr;
				awready_reg <= 1'b0;
			end
			if (wvalid && wready_reg)
			begin
				wData_reg <= wdata;
				wStrb_reg <= wstrb;
				wready_reg <= 1'b0;
			end
			if (wrFire)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wrMapped ? mcast_pkg::RESP_OKAY :
					mcast_pkg::RESP_SLVERR;
			end
			else if (bvalid_reg && bready)
			begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	//--------------------------------------------------------------------
	// AXI4-Lite read channel
	//--------------------------------------------------------------------
	logic rdMapped;
	logic [31:0] rdWord;

	assign rdMapped = (araddr[ADDR_W-1:4] == '0) && (araddr[1:0] == 2'h0);

	// mask and association read words carry the verify results in bit 0
	always_comb
	begin
		rdWord = mcast_pkg::WORD_RESET;
		unique case (araddr[3:0])
			mcast_pkg::OFS_MASK_CFG:
				rdWord = {maskCfg_reg[31:1], presentFlag_reg}; // [R16]
			mcast_pkg::OFS_DESTID_CFG:
				rdWord = destIdCfg_reg;
			mcast_pkg::OFS_ASSOC:
				rdWord = {assocCfg_reg[31:1], bindingValidFlag_reg}; // [R16]
			mcast_pkg::OFS_INFO:
				rdWord = {16'h0000, MASK_LIMIT}; // mask-count capability
			default:
				rdWord = mcast_pkg::WORD_RESET;
		endcase
		if (!rdMapped)
			rdWord = mcast_pkg::WORD_RESET;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= mcast_pkg::WORD_RESET;
			rresp_reg <= mcast_pkg::RESP_OKAY;
		end
		else if (arvalid && arready_reg)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rdWord;
			rresp_reg <= rdMapped ? mcast_pkg::RESP_OKAY :
				mcast_pkg::RESP_SLVERR;
		end
		else if (rvalid_reg && rready)
		begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	//--------------------------------------------------------------------
	// configuration words and verify flags
	//--------------------------------------------------------------------
	// verify results are taken when the command is written, read later
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			maskCfg_reg <= mcast_pkg::WORD_RESET;
			destIdCfg_reg <= mcast_pkg::WORD_RESET;
			assocCfg_reg <= mcast_pkg::WORD_RESET;
			presentFlag_reg <= 1'b0;
			bindingValidFlag_reg <= 1'b0;
		end
		else
		begin
			if (wrMask)
			begin
				maskCfg_reg <= wData_reg;
				presentFlag_reg <= (cfgCmd == mcast_pkg::MCMD_VERIFY) &&
					cfgMaskOk && (cfgPort <= mcast_pkg::LAST_PORT) &&
					engMask_reg[cfgIdx][cfgPort[3:0]]; // [R16]
			end
			if (wrDest)
				destIdCfg_reg <= wData_reg; // [R10]
			if (wrAssoc)
			begin
				assocCfg_reg <= wData_reg;
				bindingValidFlag_reg <= (assocCmd == mcast_pkg::ACMD_VERIFY) &&
					destMaskOk &&
					mcast_pkg::entryHit(engTable_reg[destIdx], destId,
						destTt); // [R16]
			end
		end
	end

	//--------------------------------------------------------------------
	// group table, one next value for both copies
	//--------------------------------------------------------------------
	// bind replaces the mask's ID and frees any other entry with the pair
	always_comb
	begin
		table_next = engTable_reg;
		if (wrAssoc && destMaskOk)
		begin
			if (assocCmd == mcast_pkg::ACMD_BIND) // [R11]
			begin
				for (int i = 0; i < ENT; i++)
				begin
					if (mcast_pkg::entryHit(engTable_reg[i], destId, destTt))
						table_next[i].valid = 1'b0; // [R12]
				end
				table_next[destIdx].valid = 1'b1; // [R12]
				table_next[destIdx].tt = destTt;
				table_next[destIdx].id = destId;
			end
			else if (assocCmd == mcast_pkg::ACMD_REMOVE &&
				mcast_pkg::entryHit(engTable_reg[destIdx], destId, destTt))
				table_next[destIdx].valid = 1'b0; // [R15] [R22]
		end
	end

	// both copies load together, so no lookup sees a half-made group
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ingTable_reg <= '0;
			engTable_reg <= '0;
		end
		else
		begin
			ingTable_reg <= table_next; // [R2] [R24]
			engTable_reg <= table_next; // [R2] [R24]
		end
	end

	//--------------------------------------------------------------------
	// port masks
	//--------------------------------------------------------------------
	// no port-state input: disabled ports are edited like any other
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			engMask_reg <= '0;
		else if (wrMask && cfgMaskOk) // [R7]
		begin
			unique case (cfgCmd)
				mcast_pkg::MCMD_ADD:
					if (cfgPort <= mcast_pkg::LAST_PORT) // [R8] [R9]
						engMask_reg[cfgIdx][cfgPort[3:0]] <= 1'b1;
				mcast_pkg::MCMD_DEL:
					if (cfgPort <= mcast_pkg::LAST_PORT) // [R8] [R13]
						engMask_reg[cfgIdx][cfgPort[3:0]] <= 1'b0;
				mcast_pkg::MCMD_DEL_ALL:
					engMask_reg[cfgIdx] <= '0; // [R23]
				mcast_pkg::MCMD_ADD_ALL:
					engMask_reg[cfgIdx] <= '1;
				default:
					engMask_reg <= engMask_reg; // verify and reserved
			endcase
		end
	end

	//--------------------------------------------------------------------
	// lookup pipeline: ingress stage then replication engine stage
	//--------------------------------------------------------------------
	logic ingHit, engHit;
	logic [mcast_pkg::GROUP_W-1:0] ingIdx, engIdx;
	logic [NP-1:0] engVector;

	group_match #(.ENTRIES(ENT)) u_ingress_match (
		.groups(ingTable_reg),
		.destId(pkt.destId),
		.tt(pkt.tt),
		.hit(ingHit),
		.index(ingIdx)
	);

	group_match #(.ENTRIES(ENT)) u_engine_match (
		.groups(engTable_reg),
		.destId(s1Pkt_reg.destId),
		.tt(s1Pkt_reg.tt),
		.hit(engHit),
		.index(engIdx)
	);

	// arrival port always struck out; port health is not consulted
	assign engVector = engMask_reg[engIdx] &
		~(16'h0001 << s1Pkt_reg.ingress); // [R5] [R14]

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1Valid_reg <= 1'b0;
			s1Hit_reg <= 1'b0;
			s1Pkt_reg <= '0;
			fwdValid_reg <= 1'b0;
			fwd_reg <= '0;
		end
		else
		begin
			s1Valid_reg <= pktValid;
			s1Hit_reg <= ingHit; // [R1] [R4]
			s1Pkt_reg <= pkt;
			fwdValid_reg <= s1Valid_reg;
			fwd_reg.multicast <= s1Hit_reg; // [R4] [R6]
			fwd_reg.ingress <= s1Pkt_reg.ingress;
			fwd_reg.group <= engIdx;
			fwd_reg.vector <= (s1Hit_reg && engHit) ? engVector : '0;
			// unbound in between, or nothing left to send to: discard
			fwd_reg.drop <= s1Hit_reg &&
				(!engHit || engVector == '0); // [R17]
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign fwdValid = fwdValid_reg;
	assign fwd = fwd_reg;

	//--------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence lookupHit;
		pktValid && ingHit;
	endsequence
	sequence lookupMiss;
		pktValid && !ingHit;
	endsequence

	hit_forward_a: assert property (lookupHit |-> ##2 (fwdValid && fwd.multicast)) else $error("hit not sent to engine"); // [R4]
	miss_unicast_a: assert property (lookupMiss |-> ##2 (fwdValid && !fwd.multicast && fwd.vector == '0)) else $error("miss not unicast"); // [R6]
	no_echo_a: assert property (fwdValid |-> !fwd.vector[fwd.ingress]) else $error("copy to arrival port"); // [R5]
	empty_drop_a: assert property ((fwdValid && fwd.multicast) |-> (fwd.drop == (fwd.vector == '0))) else $error("drop mismatch"); // [R17]
	port_range_a: assert property ((wrMask && cfgPort > mcast_pkg::LAST_PORT && cfgCmd != mcast_pkg::MCMD_DEL_ALL && cfgCmd != mcast_pkg::MCMD_ADD_ALL) |=> $stable(engMask_reg)) else $error("bad port changed mask"); // [R8]
	mask_limit_a: assert property ((wrMask && !cfgMaskOk) |=> $stable(engMask_reg)) else $error("bad mask changed"); // [R7]
	assoc_bind_a: assert property ((wrAssoc && destMaskOk && assocCmd == mcast_pkg::ACMD_BIND) |=> (engTable_reg[$past(destIdx)].valid && engTable_reg[$past(destIdx)].id == $past(destId))) else $error("bind missing"); // [R11]
	assoc_remove_a: assert property ((wrAssoc && destMaskOk && assocCmd == mcast_pkg::ACMD_REMOVE) |=> !engTable_reg[$past(destIdx)].valid || engTable_reg[$past(destIdx)].id != $past(destId)) else $error("remove failed"); // [R22]
	copies_agree_a: assert property (ingTable_reg == engTable_reg) else $error("table copies differ"); // [R24]
	write_answer_a: assert property (wrFire |=> bvalid) else $error("write not answered"); // [R10]
endmodule // multicast_group_lookup

// file: verif/pkt_source.sv
// packet header source standing in for the link partners
`timescale 1ns/1ps
module pkt_source (
	input wire logic clock,
	output logic pktValid,
	output mcast_pkg::pkt_t pkt
);
	// idle at time zero, no header offered
	initial
	begin
		pktValid = 1'h0;
		pkt = '0;
	end

	// one header per call; scrambled after use so a stale header never
	// looks like a live one
	task automatic send(input logic [15:0] id, input logic tt,
		input logic [3:0] ing);
		@(posedge clock);
		pktValid <= 1'h1;
		pkt <= '{destId: id, tt: tt, ingress: ing};
		@(posedge clock);
		pktValid <= 1'h0;
		pkt <= mcast_pkg::pkt_t'(~pkt);
	endtask
endmodule // pkt_source

// file: verif/multicast_group_lookup_tb_top.sv
// self-checking bench for the multicast group lookup
`timescale 1ns/1ps
module multicast_group_lookup_tb_top;
	logic clock = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
	logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, pktValid, fwdValid;
	logic [1:0] bresp, rresp;
	mcast_pkg::pkt_t pkt;
	mcast_pkg::fwd_t fwd;
	int failures = 0, cmp_count = 0;

	// 200 MHz clock
	always #2.5 clock = ~clock;

	// six masks so that masks 6 and 7 are out of range
	multicast_group_lookup #(.MAX_MASKS(6), .ADDR_W(12)) u_dut (
		.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pktValid(pktValid), .pkt(pkt), .fwdValid(fwdValid), .fwd(fwd)
	);

	pkt_source u_src (.clock(clock), .pktValid(pktValid), .pkt(pkt));

	//--------------------------------------------------------------
	// bus and compare tasks
	//--------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// values read right after an edge are the ones sampled at it
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge clock);
			n++;
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
		end
		while (bvalid !== 1'h1 && n < 40);
		bready <= 1'h0;
		// a write that never got its answer is a mismatch, not a pass
		chk("bvalid", 32'h1, 32'(bvalid));
		chk("bresp", 32'(mcast_pkg::RESP_OKAY), 32'(bresp));
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge clock);
			n++;
			if (arvalid && arready)
				arvalid <= 1'h0;
		end
		while (rvalid !== 1'h1 && n < 40);
		chk("rvalid", 32'h1, 32'(rvalid));
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", 32'(mcast_pkg::RESP_OKAY), 32'(r));
	endtask

	// group index checked only where a scenario names the expected entry
	task automatic look(input logic [15:0] id, input logic tt,
		input logic [3:0] ing, input logic mc, input logic dr,
		input logic [15:0] v, input int g = -1);
		int n = 0;
		u_src.send(id, tt, ing);
		do
		begin
			@(posedge clock);
			n++;
		end
		while (fwdValid !== 1'h1 && n < 4);
		chk("fwdValid", 32'h1, 32'(fwdValid));
		chk("fwd", 32'({mc, dr, ing, v}),
			32'({fwd.multicast, fwd.drop, fwd.ingress, fwd.vector}));
		if (g >= 0)
			chk("group", 32'(g), 32'(fwd.group));
	endtask

	//--------------------------------------------------------------
	// scenarios
	//--------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rdChk(12'h000, 32'h0000_0000);
		rd(12'h00C, d, r);
		chk("maxMasks", 32'h0000_0006, {16'h0000, d[15:0]});
		rd(12'h010, d, r);
		chk("unmapped", 32'(mcast_pkg::RESP_SLVERR), 32'(r));
		chk("unmappedData", 32'h0000_0000, d);
		// a partial word must leave the set-up register untouched
		wstrb <= 4'h3;
		wr(12'h004, 32'hABCD_0001);
		wstrb <= 4'hF;
		rdChk(12'h004, 32'h0000_0000);
	endtask

	task automatic t_build;
		for (int m = 0; m < 4; m++)
			wr(12'h000, {16'(m), 16'h0040});
		wr(12'h000, 32'h0000_0610);
		wr(12'h000, 32'h0000_0710);
		wr(12'h000, 32'h0001_0310);
		wr(12'h000, 32'h0001_0410);
		wr(12'h000, 32'h0001_0510);
		wr(12'h000, 32'h0002_0050);
		wr(12'h004, 32'h1234_0000);
		rdChk(12'h004, 32'h1234_0000);
		wr(12'h008, 32'h0000_00E0);
		wr(12'h004, 32'h0044_0001);
		wr(12'h008, 32'h0000_0060);
		wr(12'h004, 32'hFEED_0002);
		wr(12'h008, 32'h0000_00E0);
	endtask

	task automatic t_lookup;
		look(16'h1234, 1'h0, 4'h6, 1'h1, 1'h0, 16'h0080, 0);
		look(16'h0044, 1'h1, 4'h0, 1'h1, 1'h0, 16'h0038, 1);
		look(16'h0044, 1'h0, 4'h0, 1'h0, 1'h0, 16'h0000);
		look(16'h1234, 1'h1, 4'h0, 1'h0, 1'h0, 16'h0000);
		look(16'hFEED, 1'h0, 4'h3, 1'h1, 1'h0, 16'hFFF7, 2);
		look(16'h9999, 1'h0, 4'h3, 1'h0, 1'h0, 16'h0000);
	endtask

	task automatic t_verify;
		wr(12'h000, 32'h0002_0400);
		rdChk(12'h000, 32'h0002_0401);
		wr(12'h000, 32'h0001_0420);
		wr(12'h000, 32'h0001_0400);
		rdChk(12'h000, 32'h0001_0400);
		look(16'h0044, 1'h1, 4'h0, 1'h1, 1'h0, 16'h0028);
		wr(12'h004, 32'h0044_0001);
		wr(12'h008, 32'h0000_0000);
		rdChk(12'h008, 32'h0000_0001);
	endtask

	// mask 8 aliases mask 0 in the low index bits: it must not leak in
	task automatic t_range;
		wr(12'h000, 32'h0000_1010);
		wr(12'h000, 32'h0008_0050);
		look(16'h1234, 1'h0, 4'h0, 1'h1, 1'h0, 16'h00C0);
		wr(12'h000, 32'h0006_0050);
		wr(12'h004, 32'h0777_0006);
		wr(12'h008, 32'h0000_00E0);
		look(16'h0777, 1'h0, 4'h0, 1'h0, 1'h0, 16'h0000);
	endtask

	task automatic t_selfOnly;
		wr(12'h000, 32'h0003_0210);
		wr(12'h004, 32'h0055_0003);
		wr(12'h008, 32'h0000_00E0);
		look(16'h0055, 1'h0, 4'h2, 1'h1, 1'h1, 16'h0000);
		look(16'h0055, 1'h0, 4'h5, 1'h1, 1'h0, 16'h0004);
	endtask

	// present bit set on purpose: the remove must not look at it
	task automatic t_unbind;
		wr(12'h004, 32'hFEED_0002);
		wr(12'h008, 32'h0000_00C1);
		look(16'hFEED, 1'h0, 4'h3, 1'h0, 1'h0, 16'h0000);
		wr(12'h008, 32'h0000_0080);
		rdChk(12'h008, 32'h0000_0080);
	endtask

	task automatic t_rebind;
		wr(12'h004, 32'h0ABC_0000);
		wr(12'h008, 32'h0000_00E0);
		look(16'h1234, 1'h0, 4'h1, 1'h0, 1'h0, 16'h0000);
		look(16'h0ABC, 1'h0, 4'h1, 1'h1, 1'h0, 16'h00C0, 0);
	endtask

	//--------------------------------------------------------------
	// run control
	//--------------------------------------------------------------
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// reset for two cycles, then every scenario in turn
	initial
	begin
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		t_regs;
		t_build;
		t_lookup;
		t_verify;
		t_range;
		t_selfOnly;
		t_unbind;
		t_rebind;
		final_report;
	end

	// the run needs well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge clock);
		failures++;
		final_report;
	end
endmodule // multicast_group_lookup_tb_top
